// ===== hdl/ccr_config_regs.sv
// Converter configuration and identity registers behind an I2C target
//
// Function
// R1: Follower link clock phase 0/90/180/270 degrees
// R2: Peak current limit 4800 mA plus 450/code
// R3: Host sets comparator disable once, statically
// R4: Good threshold 2.50 V plus 0.10 V, saturating
// R5: Startup current 500 mA steps, reset code 3
// R6: Undervoltage hysteresis 50 mV steps, reset 3
// R7: Host programs critical level at least 5.00 V
// R8: Regulator off: core-supplied pads, open-drain only
// R9: Power-cycle pause none/10/100/500 ms before reboot
// R10: I/O supply level 1.5/1.8/2.8/3.3 V
// R11: Warning level 5.2 V plus 0.2 V/code
// R12: Bus address is field then three zeros
// R13: Variant register: mask and package revision
// R14: Platform code register, resets to zero
// R15: Setting revision zero means unconfigured
// R16: Lock region writes blocked unless key written
// R17: Reserved fields stay at their reset values
`timescale 1ns/1ps
module ccr_config_regs
  import ccr_pkg::*;
#(
  parameter int unsigned PAUSE_SHORT_CYC = CCR_PAUSE_SHORT_MS * CCR_CYC_PER_MS,
  parameter int unsigned PAUSE_MID_CYC = CCR_PAUSE_MID_MS * CCR_CYC_PER_MS,
  parameter int unsigned PAUSE_LONG_CYC = CCR_PAUSE_LONG_MS * CCR_CYC_PER_MS,
  parameter int unsigned PHASE_QUARTER_CYC = 4,
  parameter logic [7:0] PART_IDENTITY = 8'h5a // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic companion_mode,
  input wire logic power_cycle_req,
  output logic converter_clock,
  output logic follower_link_clock,
  output logic [13:0] peak_current_limit_ma,
  output logic good_comparator_disable,
  output logic [13:0] good_threshold_cv,
  output logic [13:0] startup_current_ma,
  output logic [13:0] undervoltage_hysteresis_mv,
  output logic [13:0] undervoltage_critical_cv,
  output logic [13:0] undervoltage_warning_cv,
  output logic io_supply_regulator_enable,
  output logic pads_from_core_supply,
  output logic open_drain_only,
  output logic [13:0] io_supply_level_mv,
  output logic pause_active,
  output logic reboot_go,
  output logic [6:0] device_address,
  output logic [3:0] mask_revision_code,
  output logic [3:0] package_variant_code,
  output logic [7:0] platform_code,
  output logic [7:0] setting_revision,
  output logic otp_configured
);

  // ====================
  // Pin synchronisation and bus edge detection
  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  ccr_sync2 #(.W(2), .RST_VAL(2'h3)) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .d({scl_in, sda_in}),
    .q({scl_s, sda_s})
  );

  // Previous sampled levels for edge detection
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // SDA moving while SCL is high marks start and stop
  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  assign bus_start = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign bus_stop = scl_s && scl_p_q && !sda_p_q && sda_s;

  // ====================
  // Register state
  logic [7:0] ctrl_b_q, ctrl_b_d;
  logic [7:0] ctrl_c_q, ctrl_c_d;
  logic [7:0] uv_q, uv_d;
  logic [7:0] iof_q, iof_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] rev_q, rev_d;
  logic [7:0] plat_q, plat_d;
  logic [7:0] setrev_q, setrev_d;
  logic unlocked_q, unlocked_d;
  logic [7:0] rdata;
  logic region_blocked;

  // ====================
  // I2C target engine
  ccr_i2c_state_t st_q, st_d;
  logic [3:0] bits_q, bits_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] ptr_q, ptr_d;
  logic rd_q, rd_d;
  logic ack_q, ack_d;
  logic oe_n_q, oe_n_d;
  logic wr_en;

  assign device_address = {addr_q[CCR_BADDR_LSB +: 4], CCR_ADDR_LOW_BITS}; // R12

  // Byte engine: sample on SCL rise, change SDA after SCL fall
  always_comb begin
    st_d = st_q;
    bits_d = bits_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    rd_d = rd_q;
    ack_d = ack_q;
    oe_n_d = oe_n_q;
    wr_en = 1'b0;
    if (bus_start) begin
      st_d = CCR_I2C_ADDR;
      bits_d = '0;
      oe_n_d = 1'b1;
    end else if (bus_stop) begin
      st_d = CCR_I2C_IDLE;
      oe_n_d = 1'b1;
    end else begin
      unique case (st_q)
        CCR_I2C_IDLE: begin
          oe_n_d = 1'b1;
        end
        CCR_I2C_ADDR, CCR_I2C_PTR, CCR_I2C_WDAT: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s};
            bits_d = bits_q + 4'h1;
          end
          if (scl_fall && bits_q == CCR_BITS_PER_BYTE) begin
            bits_d = '0;
            if (st_q == CCR_I2C_ADDR) begin
              // Foreign addresses are ignored until the next start
              if (shift_q[7:1] == device_address) begin // R12
                st_d = CCR_I2C_ADDR_ACK;
                oe_n_d = 1'b0;
                rd_d = shift_q[0];
              end else begin
                st_d = CCR_I2C_IDLE;
              end
            end else if (st_q == CCR_I2C_PTR) begin
              ptr_d = shift_q;
              st_d = CCR_I2C_PTR_ACK;
              oe_n_d = 1'b0;
            end else begin
              // Locked or unmapped writes are still acknowledged
              wr_en = 1'b1;
              ptr_d = ptr_q + 8'h01;
              st_d = CCR_I2C_WDAT_ACK;
              oe_n_d = 1'b0;
            end
          end
        end
        CCR_I2C_ADDR_ACK: begin
          if (scl_fall) begin
            if (rd_q) begin
              st_d = CCR_I2C_RDAT;
              shift_d = rdata;
              oe_n_d = rdata[7];
            end else begin
              st_d = CCR_I2C_PTR;
              oe_n_d = 1'b1;
            end
          end
        end
        CCR_I2C_PTR_ACK, CCR_I2C_WDAT_ACK: begin
          if (scl_fall) begin
            st_d = CCR_I2C_WDAT;
            oe_n_d = 1'b1;
          end
        end
        CCR_I2C_RDAT: begin
          if (scl_rise) begin
            bits_d = bits_q + 4'h1;
          end
          if (scl_fall) begin
            if (bits_q == CCR_BITS_PER_BYTE) begin
              st_d = CCR_I2C_RDAT_ACK;
              bits_d = '0;
              oe_n_d = 1'b1;
              ptr_d = ptr_q + 8'h01;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              oe_n_d = shift_q[6];
            end
          end
        end
        CCR_I2C_RDAT_ACK: begin
          if (scl_rise) begin
            ack_d = !sda_s;
          end
          if (scl_fall) begin
            if (ack_q) begin
              st_d = CCR_I2C_RDAT;
              shift_d = rdata;
              oe_n_d = rdata[7];
            end else begin
              st_d = CCR_I2C_IDLE;
            end
          end
        end
        default: begin
          st_d = CCR_I2C_IDLE;
          oe_n_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_q <= CCR_I2C_IDLE;
      bits_q <= '0;
      shift_q <= '0;
      ptr_q <= '0;
      rd_q <= 1'b0;
      ack_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      bits_q <= bits_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      rd_q <= rd_d;
      ack_q <= ack_d;
      oe_n_q <= oe_n_d;
    end
  end

  // Open drain: the pad only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = oe_n_q;

  // ====================
  // Register file
  assign region_blocked = (ptr_q >= CCR_LOCK_LO) && (ptr_q <= CCR_LOCK_HI) && !unlocked_q; // R16

  // Write decode; reserved bits are forced back to reset values
  always_comb begin
    ctrl_b_d = ctrl_b_q;
    ctrl_c_d = ctrl_c_q;
    uv_d = uv_q;
    iof_d = iof_q;
    addr_d = addr_q;
    rev_d = rev_q;
    plat_d = plat_q;
    setrev_d = setrev_q;
    unlocked_d = unlocked_q;
    if (wr_en && ptr_q == CCR_OFS_LOCK) begin
      unlocked_d = (shift_q == CCR_UNLOCK_KEY); // R16
    end else if (wr_en && !region_blocked) begin // R16
      case (ptr_q)
        CCR_OFS_CTRL_B: ctrl_b_d = ccr_wr(shift_q, CCR_WMASK_CTRL_B, CCR_RST_CTRL_B); // R17
        CCR_OFS_CTRL_C: ctrl_c_d = shift_q;
        CCR_OFS_UV: uv_d = shift_q;
        CCR_OFS_IOF: iof_d = shift_q;
        CCR_OFS_ADDR: addr_d = ccr_wr(shift_q, CCR_WMASK_ADDR, CCR_RST_ADDR); // R17
        CCR_OFS_REV: rev_d = shift_q; // R13
        CCR_OFS_PLAT: plat_d = shift_q; // R14
        CCR_OFS_SETREV: setrev_d = shift_q; // R15
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_b_q <= CCR_RST_CTRL_B; // R1 R2
      ctrl_c_q <= CCR_RST_CTRL_C; // R4 R5
      uv_q <= CCR_RST_UV; // R6
      iof_q <= CCR_RST_IOF; // R8 R9 R10 R11
      addr_q <= CCR_RST_ADDR; // R12
      rev_q <= CCR_RST_ID; // R13
      plat_q <= CCR_RST_ID; // R14
      setrev_q <= CCR_RST_ID;
      unlocked_q <= 1'b0; // R16
    end else begin
      ctrl_b_q <= ctrl_b_d;
      ctrl_c_q <= ctrl_c_d;
      uv_q <= uv_d;
      iof_q <= iof_d;
      addr_q <= addr_d;
      rev_q <= rev_d;
      plat_q <= plat_d;
      setrev_q <= setrev_d;
      unlocked_q <= unlocked_d;
    end
  end

  // Read mux; loaded into the shift register at each read byte start
  always_comb begin
    case (ptr_q)
      CCR_OFS_LOCK: rdata = unlocked_q ? CCR_UNLOCK_KEY : CCR_LOCKED_READ;
      CCR_OFS_CTRL_B: rdata = ctrl_b_q;
      CCR_OFS_CTRL_C: rdata = ctrl_c_q;
      CCR_OFS_UV: rdata = uv_q;
      CCR_OFS_IOF: rdata = iof_q;
      CCR_OFS_ADDR: rdata = addr_q;
      CCR_OFS_REV: rdata = rev_q; // R13
      CCR_OFS_PART: rdata = PART_IDENTITY;
      CCR_OFS_PLAT: rdata = plat_q; // R14
      CCR_OFS_SETREV: rdata = setrev_q; // R15
      default: rdata = CCR_UNMAPPED_READ;
    endcase
  end

  // ====================
  // Power-cycle pause timer
  ccr_pause_state_t ps_q, ps_d;
  logic [31:0] pcnt_q, pcnt_d;
  logic go_q, go_d;
  logic [1:0] wait_code;

  assign wait_code = iof_q[CCR_PAUSE_LSB +: 2];

  // Wait length latched at the request; later writes do not stretch it
  always_comb begin
    ps_d = ps_q;
    pcnt_d = pcnt_q;
    go_d = 1'b0;
    unique case (ps_q)
      CCR_PS_IDLE: begin
        if (power_cycle_req) begin
          if (wait_code == CCR_WAIT_NONE) begin
            go_d = 1'b1; // R9
          end else begin
            ps_d = CCR_PS_WAIT;
            if (wait_code == CCR_WAIT_SHORT) begin
              pcnt_d = 32'(PAUSE_SHORT_CYC - 1); // R9
            end else if (wait_code == CCR_WAIT_MID) begin
              pcnt_d = 32'(PAUSE_MID_CYC - 1); // R9
            end else begin
              pcnt_d = 32'(PAUSE_LONG_CYC - 1); // R9
            end
          end
        end
      end
      CCR_PS_WAIT: begin
        if (pcnt_q == '0) begin
          ps_d = CCR_PS_IDLE;
          go_d = 1'b1; // R9
        end else begin
          pcnt_d = pcnt_q - 32'h1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ps_q <= CCR_PS_IDLE;
      pcnt_q <= '0;
      go_q <= 1'b0;
    end else begin
      ps_q <= ps_d;
      pcnt_q <= pcnt_d;
      go_q <= go_d;
    end
  end

  assign pause_active = (ps_q == CCR_PS_WAIT);
  assign reboot_go = go_q;

  // ====================
  // Follower link clock
  ccr_phase_gen #(.QUARTER_CYC(PHASE_QUARTER_CYC)) u_phase (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .enable(companion_mode),
    .phase(ctrl_b_q[CCR_PHASE_LSB +: 2]), // R1
    .converter_clock(converter_clock),
    .follower_link_clock(follower_link_clock)
  );

  // ====================
  // Decoded settings to the analog side, registered
  logic [13:0] ilim_d, pg_d, stup_d, hys_d, crit_d, warn_d, io_d;
  logic [4:0] pg_code;

  always_comb begin
    pg_code = ctrl_c_q[CCR_PGADJ_LSB +: 5];
    if (pg_code > CCR_PG_MAX_CODE) begin
      pg_code = CCR_PG_MAX_CODE; // R4
    end
    ilim_d = ccr_lin(CCR_ILIM_BASE_MA, CCR_ILIM_STEP_MA,
                     {1'b0, ctrl_b_q[CCR_ILIM_LSB +: 4]}); // R2
    pg_d = ccr_lin(CCR_PG_BASE_CV, CCR_PG_STEP_CV, pg_code); // R4
    stup_d = ccr_lin(CCR_STUP_STEP_MA, CCR_STUP_STEP_MA,
                     {3'h0, ctrl_c_q[CCR_STUP_LSB +: 2]}); // R5
    hys_d = ccr_lin(CCR_HYS_STEP_MV, CCR_HYS_STEP_MV, {2'h0, uv_q[CCR_HYS_LSB +: 3]}); // R6
    crit_d = ccr_lin(CCR_CRIT_BASE_CV, CCR_CRIT_STEP_CV, uv_q[CCR_CRIT_LSB +: 5]);
    warn_d = ccr_lin(CCR_WARN_BASE_CV, CCR_WARN_STEP_CV,
                     {2'h0, iof_q[CCR_WARN_LSB +: 3]}); // R11
    unique case (iof_q[CCR_IOLVL_LSB +: 2]) // R10
      2'h0: io_d = CCR_IO_MV_0;
      2'h1: io_d = CCR_IO_MV_1;
      2'h2: io_d = CCR_IO_MV_2;
      2'h3: io_d = CCR_IO_MV_3;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      peak_current_limit_ma <= '0;
      good_threshold_cv <= '0;
      startup_current_ma <= '0;
      undervoltage_hysteresis_mv <= '0;
      undervoltage_critical_cv <= '0;
      undervoltage_warning_cv <= '0;
      io_supply_level_mv <= '0;
    end else begin
      peak_current_limit_ma <= ilim_d;
      good_threshold_cv <= pg_d;
      startup_current_ma <= stup_d;
      undervoltage_hysteresis_mv <= hys_d;
      undervoltage_critical_cv <= crit_d;
      undervoltage_warning_cv <= warn_d;
      io_supply_level_mv <= io_d;
    end
  end

  // Direct register bits; pads fall back to the core supply
  assign good_comparator_disable = ctrl_c_q[CCR_PGDIS_BIT];
  assign io_supply_regulator_enable = iof_q[CCR_IOEN_BIT]; // R8
  assign pads_from_core_supply = !iof_q[CCR_IOEN_BIT]; // R8
  assign open_drain_only = pads_from_core_supply; // R8
  assign mask_revision_code = rev_q[CCR_MRC_LSB +: 4]; // R13
  assign package_variant_code = rev_q[CCR_VRC_LSB +: 4]; // R13
  assign platform_code = plat_q;
  assign setting_revision = setrev_q;
  assign otp_configured = |setrev_q; // R15

endmodule

// ===== shared/ccr_pkg.sv
// Constants, register map and decode helpers shared by the converter register block
package ccr_pkg;

  // ====================
  // Clock and timing
  localparam int unsigned CCR_CLK_PERIOD_NS = 5;
  localparam int unsigned CCR_CYC_PER_MS = 1000000 / CCR_CLK_PERIOD_NS;
  localparam int unsigned CCR_PAUSE_SHORT_MS = 10;
  localparam int unsigned CCR_PAUSE_MID_MS = 100;
  localparam int unsigned CCR_PAUSE_LONG_MS = 500;

  // ====================
  // Register offsets and lock region
  localparam logic [7:0] CCR_OFS_LOCK = 8'h0d;
  localparam logic [7:0] CCR_OFS_CTRL_B = 8'h0f;
  localparam logic [7:0] CCR_OFS_CTRL_C = 8'h10;
  localparam logic [7:0] CCR_OFS_UV = 8'h11;
  localparam logic [7:0] CCR_OFS_IOF = 8'h13;
  localparam logic [7:0] CCR_OFS_ADDR = 8'h14;
  localparam logic [7:0] CCR_OFS_REV = 8'h30;
  localparam logic [7:0] CCR_OFS_PART = 8'h31;
  localparam logic [7:0] CCR_OFS_PLAT = 8'h32;
  localparam logic [7:0] CCR_OFS_SETREV = 8'h33;
  localparam logic [7:0] CCR_LOCK_LO = 8'h0e;
  localparam logic [7:0] CCR_LOCK_HI = 8'h2f;
  localparam logic [7:0] CCR_UNLOCK_KEY = 8'h4a;
  localparam logic [7:0] CCR_LOCKED_READ = 8'h00;
  localparam logic [7:0] CCR_UNMAPPED_READ = 8'h00;

  // ====================
  // Reset values and writable-bit masks
  localparam logic [7:0] CCR_RST_CTRL_B = 8'h1c;
  localparam logic [7:0] CCR_RST_CTRL_C = 8'h17;
  localparam logic [7:0] CCR_RST_UV = 8'h60;
  localparam logic [7:0] CCR_RST_IOF = 8'hd9;
  localparam logic [7:0] CCR_RST_ADDR = 8'hcd;
  localparam logic [7:0] CCR_RST_ID = 8'h00;
  localparam logic [7:0] CCR_WMASK_CTRL_B = 8'hcf;
  localparam logic [7:0] CCR_WMASK_ADDR = 8'h0f;

  // ====================
  // Field positions
  localparam int unsigned CCR_PHASE_LSB = 6;
  localparam int unsigned CCR_ILIM_LSB = 0;
  localparam int unsigned CCR_PGDIS_BIT = 7;
  localparam int unsigned CCR_PGADJ_LSB = 2;
  localparam int unsigned CCR_STUP_LSB = 0;
  localparam int unsigned CCR_HYS_LSB = 5;
  localparam int unsigned CCR_CRIT_LSB = 0;
  localparam int unsigned CCR_IOEN_BIT = 7;
  localparam int unsigned CCR_PAUSE_LSB = 5;
  localparam int unsigned CCR_IOLVL_LSB = 3;
  localparam int unsigned CCR_WARN_LSB = 0;
  localparam int unsigned CCR_BADDR_LSB = 0;
  localparam int unsigned CCR_MRC_LSB = 4;
  localparam int unsigned CCR_VRC_LSB = 0;

  // ====================
  // Analog scales; values in mA, mV or 10 mV units
  localparam logic [13:0] CCR_ILIM_BASE_MA = 14'h12c0;
  localparam logic [13:0] CCR_ILIM_STEP_MA = 14'h01c2;
  localparam logic [13:0] CCR_PG_BASE_CV = 14'h00fa;
  localparam logic [13:0] CCR_PG_STEP_CV = 14'h000a;
  localparam logic [4:0] CCR_PG_MAX_CODE = 5'h19;
  localparam logic [13:0] CCR_STUP_STEP_MA = 14'h01f4;
  localparam logic [13:0] CCR_HYS_STEP_MV = 14'h0032;
  localparam logic [13:0] CCR_CRIT_BASE_CV = 14'h01cc;
  localparam logic [13:0] CCR_CRIT_STEP_CV = 14'h0005;
  localparam logic [13:0] CCR_WARN_BASE_CV = 14'h0208;
  localparam logic [13:0] CCR_WARN_STEP_CV = 14'h0014;
  localparam logic [13:0] CCR_IO_MV_0 = 14'h05dc;
  localparam logic [13:0] CCR_IO_MV_1 = 14'h0708;
  localparam logic [13:0] CCR_IO_MV_2 = 14'h0af0;
  localparam logic [13:0] CCR_IO_MV_3 = 14'h0ce4;

  // ====================
  // Codes, serial bus constants and states
  localparam logic [1:0] CCR_WAIT_NONE = 2'h0;
  localparam logic [1:0] CCR_WAIT_SHORT = 2'h1;
  localparam logic [1:0] CCR_WAIT_MID = 2'h2;
  localparam logic [2:0] CCR_ADDR_LOW_BITS = 3'h0;
  localparam logic [3:0] CCR_BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    CCR_I2C_IDLE, CCR_I2C_ADDR, CCR_I2C_ADDR_ACK, CCR_I2C_PTR, CCR_I2C_PTR_ACK,
    CCR_I2C_WDAT, CCR_I2C_WDAT_ACK, CCR_I2C_RDAT, CCR_I2C_RDAT_ACK
  } ccr_i2c_state_t;

  typedef enum logic {CCR_PS_IDLE, CCR_PS_WAIT} ccr_pause_state_t;

  // Linear code-to-value map: base + step * code
  function automatic logic [13:0] ccr_lin(input logic [13:0] base, input logic [13:0] step,
                                          input logic [4:0] code);
    logic [18:0] acc;
    acc = 19'(base) + 19'(step) * 19'(code);
    return acc[13:0];
  endfunction

  // Register update that keeps non-writable bits at reset value
  function automatic logic [7:0] ccr_wr(input logic [7:0] wdata, input logic [7:0] mask,
                                        input logic [7:0] rst);
    return (wdata & mask) | (rst & ~mask);
  endfunction

endpackage

// ===== hdl/ccr_sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ccr_sync2 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// ===== hdl/ccr_phase_gen.sv
// Converter clock and phase-shifted follower link clock generator
`timescale 1ns/1ps
module ccr_phase_gen #(
  parameter int unsigned QUARTER_CYC = 4
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic [1:0] phase,
  output logic converter_clock,
  output logic follower_link_clock
);

  localparam int unsigned PER = 4 * QUARTER_CYC;
  localparam int unsigned CW = $clog2(PER);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic conv_d;
  logic foll_d;

  // Free-running period counter; follower lags by phase quarters
  always_comb begin
    int unsigned pos;
    pos = 0;
    cnt_d = (int'(cnt_q) == PER - 1) ? '0 : cnt_q + CW'(1);
    conv_d = int'(cnt_q) < PER / 2;
    pos = (int'(cnt_q) + PER - int'(phase) * QUARTER_CYC) % PER;
    // Held low outside paired operation so the companion sees no edges
    foll_d = enable && (pos < PER / 2); // R1
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cnt_q <= '0;
      converter_clock <= 1'b0;
      follower_link_clock <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      converter_clock <= conv_d;
      follower_link_clock <= foll_d;
    end
  end

endmodule

// ===== tb/ccr_i2c_host.sv
// I2C bus controller model standing in for the host processor
`timescale 1ns/1ps
module ccr_i2c_host #(
  parameter logic [6:0] TARGET = 7'h68
) (
  input wire logic sys_clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda_drv
);
  // ====================
  // Bus idles released; every change lands on a falling sys_clk edge
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic t(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Start (1,0,0) or stop (0,1,1); wide margins cover the target's late release
  task automatic cond(input logic x, input logic y, input logic z);
    t(2);
    sda_drv = x;
    t(5);
    scl = 1'b1;
    t(5);
    sda_drv = y;
    t(5);
    scl = z;
  endtask
  // One bit: data set while SCL low, sampled at the end of SCL high
  task automatic bitx(input logic b, output logic r);
    t(2);
    sda_drv = b;
    t(5);
    scl = 1'b1;
    t(5);
    r = sda_w;
    scl = 1'b0;
  endtask
  // Byte MSB first, then the ninth bit; a 1 there releases or ends a read
  task automatic bytex(input logic [7:0] d, input logic last, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(last, a);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] r;
    cond(1'b1, 1'b0, 1'b0);
    bytex({TARGET, 1'b0}, 1'b1, r);
    bytex(p, 1'b1, r);
    bytex(d, 1'b1, r);
    cond(1'b0, 1'b1, 1'b1);
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] r;
    cond(1'b1, 1'b0, 1'b0);
    bytex({TARGET, 1'b0}, 1'b1, r);
    bytex(p, 1'b1, r);
    cond(1'b1, 1'b0, 1'b0);
    bytex({TARGET, 1'b1}, 1'b1, r);
    bytex(8'hff, 1'b1, d);
    cond(1'b0, 1'b1, 1'b1);
  endtask
endmodule

// ===== tb/ccr_config_regs_props.sv
// Port assertions for the converter register block
`timescale 1ns/1ps
module ccr_config_regs_props (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic companion_mode,
  input wire logic power_cycle_req,
  input wire logic converter_clock,
  input wire logic follower_link_clock,
  input wire logic [13:0] peak_current_limit_ma,
  input wire logic io_supply_regulator_enable,
  input wire logic pads_from_core_supply,
  input wire logic open_drain_only,
  input wire logic pause_active,
  input wire logic reboot_go,
  input wire logic [6:0] device_address
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // ====================
  // Settings seen at the pins
  a_addr_low: assert property (device_address[2:0] == 3'h0)
    else $error("address low bits not zero");
  a_pads_core: assert property (pads_from_core_supply == !io_supply_regulator_enable
    && open_drain_only == pads_from_core_supply) else $error("pad supply mismatch");
  // Decoded value lags a cycle, so skip the first edge after reset
  a_ilim_grid: assert property ($past(resetn) |->
    (peak_current_limit_ma - 14'h12c0) % 14'h01c2 == 14'h0000) else $error("ilim off grid");
  // ====================
  // Clocks and power cycle
  a_follow_off: assert property (!companion_mode && !$past(companion_mode)
    |-> !follower_link_clock) else $error("follower clock without companion");
  a_conv_half: assert property ($rose(converter_clock)
    |-> converter_clock[*8] ##1 !converter_clock) else $error("converter clock shape");
  a_pause_start: assert property (power_cycle_req && !pause_active
    |=> pause_active || reboot_go) else $error("power cycle not started");
  a_reboot_pulse: assert property (reboot_go |=> !reboot_go)
    else $error("reboot pulse too long");
  a_pause_end: assert property ($fell(pause_active) |-> reboot_go)
    else $error("pause ended without reboot");
endmodule
bind ccr_config_regs ccr_config_regs_props u_props (.sys_clk, .resetn, .companion_mode,
  .power_cycle_req, .converter_clock, .follower_link_clock, .peak_current_limit_ma,
  .io_supply_regulator_enable, .pads_from_core_supply, .open_drain_only, .pause_active,
  .reboot_go, .device_address);

// ===== tb/ccr_config_regs_tb.sv
// Self-checking testbench for the converter register block
`timescale 1ns/1ps
module ccr_config_regs_tb;
  logic sys_clk, resetn, companion_mode, power_cycle_req, scl, sda_drv, sda_w;
  logic sda_oe_n, pause_active, reboot_go, pads_from_core_supply, otp_configured;
  logic [13:0] peak_current_limit_ma, good_threshold_cv, startup_current_ma;
  logic [13:0] undervoltage_hysteresis_mv, undervoltage_critical_cv, io_supply_level_mv;
  logic [6:0] device_address;
  logic [7:0] rs_ofs[9] = '{8'h0f, 8'h10, 8'h11, 8'h13, 8'h14, 8'h30, 8'h31, 8'h32, 8'h33};
  logic [7:0] rs_val[9] = '{8'h1c, 8'h17, 8'h60, 8'hd9, 8'hcd, 8'h00, 8'h5a, 8'h00, 8'h00};
  int pause_n[4] = '{0, 10, 20, 40};
  int n_mismatch = 0;
  int comparisons = 0;
  // Pull-up: either party pulls the data line low
  assign sda_w = sda_drv & sda_oe_n;
  ccr_config_regs #(.PAUSE_SHORT_CYC(10), .PAUSE_MID_CYC(20), .PAUSE_LONG_CYC(40)) u_dut (
    .sys_clk, .resetn, .scl_in(scl), .sda_in(sda_w), .sda_out(), .sda_oe_n, .companion_mode,
    .power_cycle_req, .converter_clock(), .follower_link_clock(), .peak_current_limit_ma,
    .good_comparator_disable(), .good_threshold_cv, .startup_current_ma,
    .undervoltage_hysteresis_mv, .undervoltage_critical_cv, .undervoltage_warning_cv(),
    .io_supply_regulator_enable(), .pads_from_core_supply, .open_drain_only(),
    .io_supply_level_mv, .pause_active, .reboot_go, .device_address, .mask_revision_code(),
    .package_variant_code(), .platform_code(), .setting_revision(), .otp_configured);
  ccr_i2c_host u_host (.*);
  task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rc(input logic [7:0] p, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(p, d);
    chk($sformatf("reg %h", p), 14'(exp), 14'(d));
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Hang guard, several times the expected run length
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    int n;
    resetn = 1'b0;
    companion_mode = 1'b1;
    power_cycle_req = 1'b0;
    repeat (20) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (5) @(negedge sys_clk);
    foreach (rs_ofs[i]) rc(rs_ofs[i], rs_val[i]);
    chk("ilim", 14'h27d8, peak_current_limit_ma);
    chk("addr", 14'h0068, 14'(device_address));
    $display("test reset values done");
    // Locked region ignores writes; unmapped offsets read zero
    u_host.wr(8'h0f, 8'h00);
    rc(8'h0f, 8'h1c);
    rc(8'h12, 8'h00);
    u_host.wr(8'h0d, 8'h4a);
    rc(8'h0d, 8'h4a);
    u_host.wr(8'h0f, 8'hff);
    rc(8'h0f, 8'hdf);
    chk("ilim", 14'h2d1e, peak_current_limit_ma);
    u_host.wr(8'h10, 8'hfe);
    chk("pg", 14'h01f4, good_threshold_cv);
    chk("stup", 14'h05dc, startup_current_ma);
    u_host.wr(8'h11, 8'he8);
    chk("hys", 14'h0190, undervoltage_hysteresis_mv);
    chk("crit", 14'h01f4, undervoltage_critical_cv);
    u_host.wr(8'h13, 8'h07);
    chk("core pads", 14'h0001, 14'(pads_from_core_supply));
    chk("io level", 14'h05dc, io_supply_level_mv);
    $display("test field writes done");
    // Every pause code, with the companion clock switched off
    companion_mode = 1'b0;
    for (int c = 0; c < 4; c++) begin
      u_host.wr(8'h13, {1'b1, 2'(c), 5'h1f});
      power_cycle_req = 1'b1;
      @(negedge sys_clk);
      power_cycle_req = 1'b0;
      n = 0;
      for (int k = 0; k < 100 && reboot_go !== 1'b1; k++) begin
        n += int'(pause_active === 1'b1);
        @(negedge sys_clk);
      end
      chk("pause", 14'(pause_n[c]), 14'(n));
    end
    $display("test pause done");
    // Relock, then writes into the region are dropped again
    u_host.wr(8'h0d, 8'h00);
    rc(8'h0d, 8'h00);
    u_host.wr(8'h11, 8'h00);
    rc(8'h11, 8'he8);
    u_host.wr(8'h33, 8'h05);
    rc(8'h33, 8'h05);
    chk("otp", 14'h0001, 14'(otp_configured));
    $display("test relock done");
    report_and_stop();
  end
endmodule
